// [tpm_regs.vh]
`ifndef TPM_REGS_VH
`define TPM_REGS_VH

// ==========================================================
// Register indices; the byte address is four times the index.
`define TPM_IDX_P0_MODE    9'h104
`define TPM_IDX_P0_FFCTL   9'h105
`define TPM_IDX_STATUS     9'h107
`define TPM_IDX_P2_MODE    9'h114
`define TPM_IDX_P3_MODE    9'h11c

// ==========================================================
// Field positions.
`define TPM_MODE_HI        7
`define TPM_MODE_LO        6
`define TPM_PWM_HI         5
`define TPM_PWM_LO         4
`define TPM_HCLK_HI        3
`define TPM_HCLK_LO        2
`define TPM_LCLK_HI        1
`define TPM_LCLK_LO        0
`define TPM_FF_ACT_HI      3
`define TPM_FF_ACT_LO      2
`define TPM_FF_TOG_EN      1
`define TPM_FF_TOG_SRC     0

// ==========================================================
// Codes.
`define TPM_MODE_8BIT      2'h0
`define TPM_MODE_16BIT     2'h1
`define TPM_MODE_PPG       2'h2
`define TPM_MODE_PWM       2'h3
`define TPM_ACT_INVERT     2'h0
`define TPM_ACT_SET        2'h1
`define TPM_ACT_CLEAR      2'h2
`define TPM_ACT_KEEP       2'h3
`define TPM_PWM_RESERVED   2'h0
`define TPM_PWM_LEN64      9'h040
`define TPM_PWM_LEN128     9'h080
`define TPM_PWM_LEN256     9'h100

// ==========================================================
// Reset values.
`define TPM_RST_MODE       8'h00
`define TPM_RST_FFCTL      4'hc

`endif

// [tpm_clock_mux.v]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_regs.vh"

module tpm_clock_mux #(
  parameter EXT_ALLOWED = 1
) (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Pair mode register
  input  wire [7:0] mode_reg,
  // Count sources
  input  wire       ext_in,
  input  wire       tap_one,
  input  wire       tap_four,
  input  wire       tap_sixteen,
  input  wire       tap_256,
  input  wire       low_match,
  input  wire       low_overflow,
  // Count enables
  output reg        low_count_reg,
  output reg        high_count_reg
);

  wire [1:0] mode_sel = mode_reg[`TPM_MODE_HI:`TPM_MODE_LO];
  wire [1:0] lclk_sel = mode_reg[`TPM_LCLK_HI:`TPM_LCLK_LO];
  wire [1:0] hclk_sel = mode_reg[`TPM_HCLK_HI:`TPM_HCLK_LO];
  reg        low_count_next;
  reg        high_count_next;

  always @*
  begin
    case (lclk_sel)
      2'h0:
        // The pin is only wired where the pair has one; else stopped.
        low_count_next = (EXT_ALLOWED != 0) ? ext_in : 1'b0;
      2'h1:    low_count_next = tap_one;
      2'h2:    low_count_next = tap_four;
      2'h3:    low_count_next = tap_sixteen;
      default: low_count_next = 1'b0;
    endcase
  end

  always @*
  begin
    if (mode_sel == `TPM_MODE_16BIT)
    begin
      high_count_next = low_overflow;
    end
    else
    begin
      case (hclk_sel)
        2'h0:    high_count_next = low_match;
        2'h1:    high_count_next = tap_one;
        2'h2:    high_count_next = tap_sixteen;
        2'h3:    high_count_next = tap_256;
        default: high_count_next = 1'b0;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      low_count_reg  <= 1'b0;
      high_count_reg <= 1'b0;
    end
    else
    begin
      low_count_reg  <= low_count_next;
      high_count_reg <= high_count_next;
    end
  end

endmodule

`default_nettype wire

// [tpm_top.v]
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpm_regs.vh"

module tpm_top #(
  parameter NPAIR = 2
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Avalon-MM slave
  input  wire [10:0]      avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  input  wire [3:0]       avs_byteenable,
  output reg  [31:0]      avs_readdata,
  output reg              avs_waitrequest,
  // Prescaler taps, one-cycle pulses
  input  wire             prescale_tap_one,
  input  wire             prescale_tap_four,
  input  wire             prescale_tap_sixteen,
  input  wire             prescale_tap_256,
  // Pin and counter core events
  input  wire             external_count_input,
  input  wire [NPAIR-1:0] low_match,
  input  wire [NPAIR-1:0] low_overflow,
  input  wire             pair0_low_match,
  input  wire             pair0_high_match,
  // Count enables, index 0 is pair two, index 1 pair three
  output wire [NPAIR-1:0] low_count,
  output wire [NPAIR-1:0] high_count,
  // Pair configuration
  output reg  [2*NPAIR-1:0] pair_operation_mode,
  output reg  [9*NPAIR-1:0] pwm_period_length,
  output reg  [NPAIR-1:0]   programmable_pulse_mode,
  // Flip-flop
  output reg              timer_output_flipflop
);

  // ==========================================================
  // Bus decode.
  wire [8:0] reg_index = avs_address[10:2];
  wire       request   = avs_read | avs_write;
  wire       hit_p0m   = (reg_index == `TPM_IDX_P0_MODE);
  wire       hit_ff    = (reg_index == `TPM_IDX_P0_FFCTL);
  wire       hit_st    = (reg_index == `TPM_IDX_STATUS);
  wire       hit_p2m   = (reg_index == `TPM_IDX_P2_MODE);
  wire       hit_p3m   = (reg_index == `TPM_IDX_P3_MODE);
  // The write lands on the edge where the master sees waitrequest low.
  wire       wr_take   = avs_write & ~avs_waitrequest & avs_byteenable[0];
  // A request held with waitrequest high is taken; read and write share it.
  wire       answer_now = request & avs_waitrequest;

  // ==========================================================
  // Write strobes, one per register.
  // Only byte lane 0 carries register bits; the upper lanes are dropped.
  wire       wr_p0m    = wr_take & hit_p0m;
  wire       wr_ff     = wr_take & hit_ff;
  wire       wr_p2m    = wr_take & hit_p2m;
  wire       wr_p3m    = wr_take & hit_p3m;

  // ==========================================================
  // Registers.
  reg  [7:0] pair0_mode_reg;
  reg  [7:0] pair2_mode_select_reg;
  reg  [7:0] pair3_mode_select_reg;
  reg  [3:0] pair0_flipflop_control_reg;
  reg  [31:0] readdata_next;
  reg        flipflop_next;
  wire [2*NPAIR-1:0] mode_out_next;
  wire [9*NPAIR-1:0] pwm_len_next;
  wire [NPAIR-1:0]   ppg_next;

  wire [1:0] pair0_mode =
    pair0_mode_reg[`TPM_MODE_HI:`TPM_MODE_LO];
  wire [1:0] ff_action =
    avs_writedata[`TPM_FF_ACT_HI:`TPM_FF_ACT_LO];
  wire       tog_en  = pair0_flipflop_control_reg[`TPM_FF_TOG_EN];
  wire       tog_src = pair0_flipflop_control_reg[`TPM_FF_TOG_SRC];
  wire [7:0] pair_mode_bus [0:NPAIR-1];

  assign pair_mode_bus[0] = pair2_mode_select_reg;
  assign pair_mode_bus[1] = pair3_mode_select_reg;

  // ==========================================================
  // Toggle request from the selected match pulse.
  // Outside 8-bit timer mode the enable and select bits are ignored,
  // because the match pulses then mean something else to the core.
  wire       mode_8bit   = (pair0_mode == `TPM_MODE_8BIT);
  wire       match_pick  = tog_src ? pair0_high_match
                                   : pair0_low_match;
  wire       toggle_req  = mode_8bit & tog_en & match_pick;

  // ==========================================================
  // Status flags for codes that software must not leave set.
  // A read straight after reset shows the reserved codes flagged.
  wire       p2_pwm_reserved =
    (pair2_mode_select_reg[`TPM_PWM_HI:`TPM_PWM_LO] == `TPM_PWM_RESERVED);
  wire       p3_pwm_reserved =
    (pair3_mode_select_reg[`TPM_PWM_HI:`TPM_PWM_LO] == `TPM_PWM_RESERVED);
  wire       p3_low_forbidden =
    (pair3_mode_select_reg[`TPM_LCLK_HI:`TPM_LCLK_LO] == 2'h0);
  wire [7:0] status_byte = {4'h0, p3_low_forbidden, p3_pwm_reserved,
                            p2_pwm_reserved, timer_output_flipflop};

  // Each register has its own process, so a decode slip on one index
  // can never disturb the contents of another.
  // Pair zero's mode register only gates the flip-flop toggle here;
  // its counting core lives outside this block.
  always @(posedge clock)
  begin
    if (rst)
    begin
      pair0_mode_reg <= `TPM_RST_MODE;
    end
    else if (wr_p0m)
    begin
      pair0_mode_reg <= avs_writedata[7:0];
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      pair2_mode_select_reg <= `TPM_RST_MODE;
    end
    else if (wr_p2m)
    begin
      pair2_mode_select_reg <= avs_writedata[7:0];
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      pair3_mode_select_reg <= `TPM_RST_MODE;
    end
    else if (wr_p3m)
    begin
      pair3_mode_select_reg <= avs_writedata[7:0];
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      pair0_flipflop_control_reg <= `TPM_RST_FFCTL;
    end
    else if (wr_ff)
    begin
      // Plain stores only; a read-modify-write would replay the
      // action field it read back and disturb the flip-flop.
      pair0_flipflop_control_reg <= avs_writedata[3:0];
    end
  end

  // ==========================================================
  // Bus answer: one wait cycle, then data and release together.
  // A request still held after its answer is taken again one cycle
  // later, so the master must drop it at the answering edge.
  always @*
  begin
    readdata_next = 32'h0000_0000;
    if (hit_p0m)
    begin
      readdata_next[7:0] = pair0_mode_reg;
    end
    else if (hit_ff)
    begin
      // Bits 4 to 6 carry nothing and simply read as zero.
      readdata_next[3:0] = pair0_flipflop_control_reg;
    end
    else if (hit_p2m)
    begin
      readdata_next[7:0] = pair2_mode_select_reg;
    end
    else if (hit_p3m)
    begin
      readdata_next[7:0] = pair3_mode_select_reg;
    end
    else if (hit_st)
    begin
      readdata_next[7:0] = status_byte;
    end
  end

  // Waitrequest drops for exactly one cycle per request.
  always @(posedge clock)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else if (answer_now)
    begin
      avs_waitrequest <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data holds until the next access, so a late look still sees it.
  always @(posedge clock)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (answer_now)
    begin
      avs_readdata <= readdata_next;
    end
  end

  // ==========================================================
  // Timer output flip-flop.
  // It resets low; software sets a start level with the action field
  // before it enables match toggles.
  always @*
  begin
    flipflop_next = timer_output_flipflop;
    if (wr_ff)
    begin
      // A software action outranks a match toggle in the same cycle.
      case (ff_action)
        `TPM_ACT_INVERT: flipflop_next = ~timer_output_flipflop;
        `TPM_ACT_SET:    flipflop_next = 1'b1;
        `TPM_ACT_CLEAR:  flipflop_next = 1'b0;
        default:         flipflop_next = timer_output_flipflop;
      endcase
    end
    else if (toggle_req)
    begin
      flipflop_next = ~timer_output_flipflop;
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      timer_output_flipflop <= 1'b0;
    end
    else
    begin
      timer_output_flipflop <= flipflop_next;
    end
  end

  // ==========================================================
  // Per pair decode and count source selection.
  // Pair two owns the pin input. Pair three's low clock code 00 leaves
  // that timer stopped, the safest answer to a code that software must
  // not set.
  genvar gi;
  generate
    for (gi = 0; gi < NPAIR; gi = gi + 1)
    begin : g_pair
      tpm_clock_mux #(
        .EXT_ALLOWED (gi == 0 ? 1 : 0)
      ) u_mux (
        .clock          (clock),
        .rst            (rst),
        .mode_reg       (pair_mode_bus[gi]),
        .ext_in         (external_count_input),
        .tap_one        (prescale_tap_one),
        .tap_four       (prescale_tap_four),
        .tap_sixteen    (prescale_tap_sixteen),
        .tap_256        (prescale_tap_256),
        .low_match      (low_match[gi]),
        .low_overflow   (low_overflow[gi]),
        .low_count_reg  (low_count[gi]),
        .high_count_reg (high_count[gi])
      );

      wire [1:0] mode_field = pair_mode_bus[gi][`TPM_MODE_HI:`TPM_MODE_LO];
      wire [1:0] pwm_field  = pair_mode_bus[gi][`TPM_PWM_HI:`TPM_PWM_LO];
      reg  [8:0] pwm_len;

      always @*
      begin
        case (pwm_field)
          2'h1:    pwm_len = `TPM_PWM_LEN64;
          2'h2:    pwm_len = `TPM_PWM_LEN128;
          2'h3:    pwm_len = `TPM_PWM_LEN256;
          // The reserved code yields zero so the core can refuse it.
          default: pwm_len = 9'h000;
        endcase
      end

      // Mode and pulse flags pass straight through; only the PWM code
      // needs a table.
      assign mode_out_next[2*gi+1:2*gi] = mode_field;
      assign ppg_next[gi] = (mode_field == `TPM_MODE_PPG);
      assign pwm_len_next[9*gi+8:9*gi] = pwm_len;
    end
  endgenerate

  // Pair outputs trail the mode registers by one cycle, so the cores
  // see clean levels with no decode glitches.
  always @(posedge clock)
  begin
    if (rst)
    begin
      pair_operation_mode <= {2*NPAIR{1'b0}};
    end
    else
    begin
      pair_operation_mode <= mode_out_next;
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      pwm_period_length <= {9*NPAIR{1'b0}};
    end
    else
    begin
      pwm_period_length <= pwm_len_next;
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      programmable_pulse_mode <= {NPAIR{1'b0}};
    end
    else
    begin
      programmable_pulse_mode <= ppg_next;
    end
  end

endmodule

`default_nettype wire

// [tpm_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_regs.vh"
// ============================================================
// Port checker
module tpm_chk #(
  parameter NPAIR = 2
) (
  // Clock, reset and bus
  input wire logic               clock,
  input wire logic               rst,
  input wire logic [10:0]        avs_address,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic               avs_waitrequest,
  // Count sources
  input wire logic               prescale_tap_one,
  input wire logic               prescale_tap_four,
  input wire logic               prescale_tap_sixteen,
  input wire logic               external_count_input,
  input wire logic [NPAIR-1:0]   low_overflow,
  // Results
  input wire logic [NPAIR-1:0]   low_count,
  input wire logic [NPAIR-1:0]   high_count,
  input wire logic [2*NPAIR-1:0] pair_operation_mode,
  input wire logic [9*NPAIR-1:0] pwm_period_length,
  input wire logic [NPAIR-1:0]   programmable_pulse_mode,
  input wire logic               timer_output_flipflop
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A control write lands only at the edge where waitrequest is low.
  wire ffw = !avs_waitrequest && avs_write && avs_byteenable[0]
    && avs_address[10:2] == `TPM_IDX_P0_FFCTL;
  wire [1:0] act = avs_writedata[3:2];
  wire       ff  = timer_output_flipflop;

  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_ff_set: assert property (ffw && act == `TPM_ACT_SET |=> ff)
    else $error("set action did not set the flip-flop");
  chk_ff_clear: assert property (ffw && act == `TPM_ACT_CLEAR |=> !ff)
    else $error("clear action did not clear the flip-flop");
  chk_ff_invert: assert property (ffw && act == `TPM_ACT_INVERT
    |=> ff != $past(ff)) else $error("invert action failed");
  chk_cascade_clock: assert property (low_overflow[0]
    ##1 pair_operation_mode[1:0] == `TPM_MODE_16BIT |-> high_count[0])
    else $error("overflow did not clock the high timer");
  chk_ppg_flag: assert property (programmable_pulse_mode[0] ==
    (pair_operation_mode[1:0] == `TPM_MODE_PPG))
    else $error("pulse mode flag disagrees with mode");
  chk_low2_source: assert property (low_count[0] |->
    $past(external_count_input | prescale_tap_one | prescale_tap_four
    | prescale_tap_sixteen)) else $error("pair two count without source");
  chk_low3_source: assert property (low_count[1] |->
    $past(prescale_tap_one | prescale_tap_four | prescale_tap_sixteen))
    else $error("pair three count without prescale tap");
  chk_reset_values: assert property ($fell(rst) |-> !ff &&
    pair_operation_mode == 0 && pwm_period_length == 0 && avs_waitrequest)
    else $error("outputs not cleared by reset");
  chk_pwm_length: assert property (pwm_period_length[8:0] inside
    {9'h000, `TPM_PWM_LEN64, `TPM_PWM_LEN128, `TPM_PWM_LEN256})
    else $error("illegal pwm period length");
endmodule

bind tpm_top tpm_chk #(.NPAIR(NPAIR)) u_chk (.clock, .rst, .avs_address,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
  .prescale_tap_one, .prescale_tap_four, .prescale_tap_sixteen,
  .external_count_input, .low_overflow, .low_count, .high_count,
  .pair_operation_mode, .pwm_period_length, .programmable_pulse_mode,
  .timer_output_flipflop);
`default_nettype wire

// [tpm_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench
module tpm_top_tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] avs_address = 11'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [10:0] src = 11'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         prescale_tap_one, prescale_tap_four, prescale_tap_sixteen;
  wire         prescale_tap_256, external_count_input;
  wire         pair0_low_match, pair0_high_match, timer_output_flipflop;
  wire  [1:0]  low_match, low_overflow, low_count, high_count;
  wire  [1:0]  programmable_pulse_mode;
  wire  [3:0]  pair_operation_mode;
  wire  [17:0] pwm_period_length;
  int          failures = 0;
  int          compares = 0;
  logic [31:0] q;
  logic [7:0]  v;
  logic        f;
  logic [1:0]  k;

  assign {pair0_high_match, pair0_low_match, low_overflow, low_match,
    prescale_tap_256, prescale_tap_sixteen, prescale_tap_four,
    prescale_tap_one, external_count_input} = src;

  tpm_top #(.NPAIR(2)) dut (.clock, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .prescale_tap_one, .prescale_tap_four,
    .prescale_tap_sixteen, .prescale_tap_256, .external_count_input,
    .low_match, .low_overflow, .pair0_low_match, .pair0_high_match,
    .low_count, .high_count, .pair_operation_mode, .pwm_period_length,
    .programmable_pulse_mode, .timer_output_flipflop);

  always #50 clock = ~clock;

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // The request stays up until the edge that samples waitrequest low.
  task xfer(input logic w, input logic [10:0] a, input logic [7:0] d,
            input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  // One-cycle source pulse; results are sampled one cycle later.
  task pulse(input logic [10:0] s);
    src <= s;
    @(posedge clock);
    src <= 11'h0;
    @(posedge clock);
  endtask

  function logic elow(input int p, input logic [1:0] c, input logic [10:0] s);
    elow = (c == 2'h0) ? (p == 0 && s[0]) : s[c];
  endfunction

  function logic ehigh(input int p, input logic [1:0] m, input logic [1:0] c,
                       input logic [10:0] s);
    if (m == 2'h1)
      ehigh = s[7+p];
    else
      ehigh = (c == 2'h0) ? s[5+p] : (c == 2'h1) ? s[1] : s[c+1];
  endfunction

  task tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    void'($urandom(32'h364e9a31));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("outputs", 32'h0, {pwm_period_length, pair_operation_mode});
    xfer(1'b0, 11'h414, 8'h0, 4'h1);
    chk("ffctl", 32'h0c, q & 32'hffffff8f);
    xfer(1'b0, 11'h7fc, 8'h0, 4'h1);
    chk("unmapped", 32'h0, q);
    xfer(1'b0, 11'h41c, 8'h0, 4'h1);
    chk("status", 32'he, q);
    for (int i = 0; i < 12; i++)
    begin
      v = $urandom;
      v[7:6] = i[1:0];
      if (v[5:4] == 2'h0) v[5:4] = 2'h1;
      if (v[1:0] == 2'h0) v[1:0] = 2'h2;
      xfer(1'b1, 11'h450, v, 4'h1);
      xfer(1'b1, 11'h470, v, 4'h1);
      xfer(1'b1, 11'h450, ~v, 4'he);
      xfer(1'b0, 11'h450, 8'h0, 4'h1);
      chk("pair2_mode_select", {24'h0, v}, q);
      chk("mode", {2{v[7:6]}}, pair_operation_mode);
      chk("ppg", {2{v[7:6] == 2'h2}}, programmable_pulse_mode);
      chk("pwm", {2{9'h20 << v[5:4]}}, pwm_period_length);
    end
    xfer(1'b0, 11'h41c, 8'h0, 4'h1);
    chk("status", 32'h0, q);
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        xfer(1'b1, 11'h450, {m[1:0], 2'h1, c[1:0], c[1:0]}, 4'h1);
        k = (c == 0) ? 2'h1 : c[1:0];
        xfer(1'b1, 11'h470, {m[1:0], 2'h1, c[1:0], k}, 4'h1);
        for (int s = 0; s < 9; s++)
        begin
          pulse(11'h1 << s);
          chk("low_count", {elow(1, k, 11'h1 << s),
            elow(0, c, 11'h1 << s)}, low_count);
          chk("high_count", {ehigh(1, m, c, 11'h1 << s),
            ehigh(0, m, c, 11'h1 << s)}, high_count);
        end
      end
    f = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      v = {4'h0, i < 4 ? i[1:0] : 2'($urandom), 2'h0};
      xfer(1'b1, 11'h414, v, 4'h1);
      f = (v[3:2] == 2'h0) ? !f : (v[3:2] == 2'h3) ? f : !v[3];
      chk("flipflop", {31'h0, f}, timer_output_flipflop);
      xfer(1'b0, 11'h414, 8'h0, 4'h1);
      chk("ffctl", {24'h0, v}, q & 32'hffffff8f);
    end
    for (int i = 0; i < 32; i++)
    begin
      xfer(1'b1, 11'h410, {i[4:3], 6'h0}, 4'h1);
      xfer(1'b1, 11'h414, {6'h3, i[2:1]}, 4'h1);
      pulse(i[0] ? 11'h400 : 11'h200);
      f = f ^ (i[4:3] == 2'h0 && i[2] && i[1] == i[0]);
      chk("toggle", {31'h0, f}, timer_output_flipflop);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
